// [lcd_cmd_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module lcd_cmd_assertions (
    input wire logic       clk_sys,
    input wire logic       reset_n,
    input wire logic       cmdSel,
    input wire logic       wrEn,
    input wire logic       rdEn,
    input wire logic [7:0] hostData,
    input wire logic [7:0] devData,
    input wire logic [3:0] displayEnable,
    input wire logic [3:0] cursorLines,
    input wire logic       autoActive
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // Command byte written to the device
    wire cmdWr = wrEn && cmdSel;
    AST_DISP_SET: assert property (
        cmdWr && hostData[7:4] == 4'h9 && !autoActive |=> displayEnable == $past(hostData[3:0]))
        else $error("display enables differ from command");
    AST_DISP_RST: assert property (
        disable iff (1'b0) !reset_n |=> displayEnable == 4'h0) else $error("enables kept in reset");
    AST_DISP_HOLD: assert property (
        $changed(displayEnable) && $past(reset_n) |-> $past(cmdWr && hostData[7:4] == 4'h9))
        else $error("enables moved without command");
    AST_CURSOR: assert property (
        cmdWr && hostData[7:3] == 5'h14 && !autoActive && displayEnable[1]
        |=> cursorLines == {1'b0, $past(hostData[2:0])} + 4'h1) else $error("cursor height wrong");
    AST_AUTO_ON: assert property (
        cmdWr && hostData[7:2] == 6'h2C && !hostData[1] |=> autoActive) else $error("auto not set");
    AST_AUTO_OFF: assert property (
        cmdWr && hostData[7:2] == 6'h2C && hostData[1] |=> !autoActive) else $error("auto not left");
    AST_AUTO_LOCK: assert property (
        autoActive && cmdWr && hostData[7:2] != 6'h2C |=> $stable(displayEnable) && $stable(cursorLines))
        else $error("command decoded in auto mode");
    AST_POLL_FIRST: assert property (
        wrEn || (rdEn && !cmdSel) |-> $past(rdEn && cmdSel, 2)) else $error("transfer without poll");
    AST_ONE_STROBE: assert property (
        !(wrEn && rdEn)) else $error("read and write together");
    // Main traffic kinds seen at least once
    COV_DISP: cover property (cmdWr && hostData[7:4] == 4'h9);
    COV_AUTO_DATA: cover property (autoActive && wrEn && !cmdSel);
    COV_DATA_READ: cover property (rdEn && !cmdSel);
endmodule : lcd_cmd_assertions
`default_nettype wire

// [lcd_cmd_device.sv]
//Contract
//- Display command holds four independent enables
//- Opcode 1001: graphics, text, cursor, blink
//- Reset clears all four display enables
//- Cursor height is code plus one
//- Auto command: 00 write, 01 read, 1x off
//- Host polls auto flags before each byte
//- Host ends auto write after write-ready flag
//- Write needs prior data byte; read none
//- Transfer bits: read, direction, hold pointer
//- Host sets pointer before single transfers
//- One byte access per transfer command
//- Peek loads displayed byte into data stack
//- Peek outside graphics ignored, error flag set
//- Copy writes one displayed row to graphics
//- Host never copies in attribute mode
//- Host never copies in dual-screen mode
//- Copy outside graphics ignored, error flag set
//- Bit command: bit3 set/clear, low three position
//- Bit command alters exactly one bit
`timescale 1ns/1ps
`default_nettype none
module lcd_cmd_device #(
    parameter int RAM_AW = 10 // Address bits of the display RAM
) (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    lcd_cmd_if.device        bus,
    input  wire logic [15:0] textBase,
    input  wire logic [15:0] gfxBase,
    input  wire logic [15:0] gfxLimit,
    input  wire logic [7:0]  rowBytes,
    input  wire logic [2:0]  mixMode,
    output logic [3:0]       displayEnable,
    output logic [3:0]       cursorLines,
    output logic             autoActive
);
    import lcd_cmd_pkg::*;

    typedef struct packed {
        dev_state_t  st;       // Command engine state
        logic [15:0] ptr;      // RAM address pointer
        logic [3:0]  dispEn;   // Graphics, text, cursor, blink
        logic [2:0]  curCode;  // Cursor height code
        logic [7:0]  dataPrev; // Older parameter byte
        logic [7:0]  dataLast; // Newest parameter byte
        logic [7:0]  stack;    // Peeked byte
        logic        stackFull;
        logic [7:0]  rdLatch;  // Byte ready for a data read
        logic [7:0]  rdOut;    // Byte driven on the port
        logic        err;      // Peek or copy error
        logic [7:0]  copyCnt;  // Bytes copied so far
    } dev_regs_t;

    dev_regs_t s;      // Current state
    dev_regs_t next_s; // Next state

    logic [7:0]        ram [2**RAM_AW]; // Display RAM
    logic              ramWe;  // RAM write this cycle
    logic [RAM_AW-1:0] ramWa;  // RAM write address
    logic [7:0]        ramWd;  // RAM write data
    logic [15:0]       cAddr;  // Copy source and target address
    logic              inGfx;  // Pointer inside graphic area
    logic [7:0]        status; // Status byte

    // Text byte that shares a screen position with a graphic address
    function automatic logic [RAM_AW-1:0] textOf(input logic [15:0] a,
                                                 input logic [15:0] tb,
                                                 input logic [15:0] gb);
        logic [15:0] t;
        t = tb + (a - gb);
        textOf = t[RAM_AW-1:0];
    endfunction : textOf

    // Displayed byte: graphic and text mixed as the mode says
    function automatic logic [7:0] mixByte(input logic [7:0] g, input logic [7:0] t,
                                           input logic [2:0] m);
        case (m)
            MIX_EXOR: mixByte = g ^ t;
            MIX_AND:  mixByte = g & t;
            MIX_OR:   mixByte = g | t;
            default:  mixByte = t; // Attribute mode shows text only
        endcase
    endfunction : mixByte

    assign inGfx = (s.ptr >= gfxBase) && (s.ptr <= gfxLimit);
    assign cAddr = s.ptr + {8'h00, s.copyCnt};

    // Status byte; a copy in flight holds off both ready bits
    always_comb begin
        status = 8'h00;
        status[ST_CMD_RDY]  = (s.st != DEV_COPY);
        status[ST_DATA_RDY] = (s.st != DEV_COPY);
        status[ST_AUTO_RD]  = (s.st == DEV_ARD);
        status[ST_AUTO_WR]  = (s.st == DEV_AWR);
        status[ST_PEEK_ERR] = s.err;
    end

    // Command, data and status decode
    always_comb begin
        next_s = s;
        ramWe = 1'b0;
        ramWa = s.ptr[RAM_AW-1:0];
        ramWd = s.dataLast;
        if (s.st == DEV_COPY) begin
            // One byte of the row per cycle, only status reads heard meanwhile
            ramWe = 1'b1;
            ramWa = cAddr[RAM_AW-1:0];
            ramWd = mixByte(ram[cAddr[RAM_AW-1:0]],
                            ram[textOf(cAddr, textBase, gfxBase)], mixMode);
            next_s.copyCnt = s.copyCnt + 8'h01;
            if (bus.rdEn && bus.cmdSel) begin
                // Busy bits must reach the host, else it judges a stale byte
                next_s.rdOut = status;
            end
            if (s.copyCnt + 8'h01 >= rowBytes) begin
                next_s.st = DEV_IDLE;
            end
        end else if (bus.rdEn) begin
            if (bus.cmdSel) begin
                // Status read
                next_s.rdOut = status;
            end else if (s.st == DEV_ARD) begin
                // Auto read: fetch and step the pointer
                next_s.rdOut = ram[s.ptr[RAM_AW-1:0]];
                next_s.ptr = s.ptr + 16'h0001;
            end else begin
                next_s.rdOut = s.rdLatch;
            end
        end else if (bus.wrEn && !bus.cmdSel) begin
            if (s.st == DEV_AWR) begin
                // Auto write: store and step the pointer
                ramWe = 1'b1;
                ramWd = bus.hostData;
                next_s.ptr = s.ptr + 16'h0001;
            end else begin
                // Parameter bytes shift through a two-deep stack
                next_s.dataPrev = s.dataLast;
                next_s.dataLast = bus.hostData;
            end
        end else if (bus.wrEn) begin
            if (isOp(bus.hostData, OP_AUTO, MSK_AUTO)) begin
                if (bus.hostData[1]) begin
                    next_s.st = DEV_IDLE;
                end else if (bus.hostData[0]) begin
                    next_s.st = DEV_ARD;
                end else begin
                    next_s.st = DEV_AWR;
                end
            end else if (s.st != DEV_IDLE) begin
                // Only auto set and reset commands are heard inside auto mode
                next_s.st = s.st;
            end else if (isOp(bus.hostData, OP_PTR_SET, MSK_PTR_SET)) begin
                next_s.ptr = {s.dataLast, s.dataPrev};
            end else if (isOp(bus.hostData, OP_DISPLAY, MSK_DISPLAY)) begin
                next_s.dispEn = bus.hostData[3:0];
            end else if (isOp(bus.hostData, OP_CURSOR, MSK_CURSOR)) begin
                next_s.curCode = bus.hostData[2:0];
            end else if (isOp(bus.hostData, OP_XFER, MSK_XFER)) begin
                // Exactly one byte per command
                if (bus.hostData[0]) begin
                    // Read: a peeked byte takes precedence over RAM
                    if (s.stackFull) begin
                        next_s.rdLatch = s.stack;
                        next_s.stackFull = 1'b0;
                    end else begin
                        next_s.rdLatch = ram[s.ptr[RAM_AW-1:0]];
                    end
                end else begin
                    ramWe = 1'b1;
                end
                if (!bus.hostData[2]) begin
                    // Direction only counts when the hold bit is clear
                    next_s.ptr = bus.hostData[1] ? s.ptr - 16'h0001
                                                 : s.ptr + 16'h0001;
                end
            end else if (isOp(bus.hostData, OP_PEEK, MSK_EXACT)) begin
                if (inGfx) begin
                    next_s.stack = mixByte(ram[s.ptr[RAM_AW-1:0]],
                        ram[textOf(s.ptr, textBase, gfxBase)], mixMode);
                    next_s.stackFull = 1'b1;
                    next_s.err = 1'b0;
                end else begin
                    next_s.err = 1'b1;
                end
            end else if (isOp(bus.hostData, OP_COPY, MSK_EXACT)) begin
                if (inGfx && rowBytes != 8'h00) begin
                    next_s.st = DEV_COPY;
                    next_s.copyCnt = 8'h00;
                    next_s.err = 1'b0;
                end else begin
                    next_s.err = 1'b1;
                end
            end else if (isOp(bus.hostData, OP_BITMOD, MSK_BITMOD)) begin
                // One bit of the pointed byte, the rest kept
                ramWe = 1'b1;
                ramWd = ram[s.ptr[RAM_AW-1:0]];
                ramWd[bus.hostData[2:0]] = bus.hostData[3];
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            s <= '0;
            s.st <= DEV_IDLE;
            s.dispEn <= 4'h0;
        end else begin
            s <= next_s;
        end
    end

    // RAM has no reset; contents are left to software
    always_ff @(posedge clk_sys) begin
        if (ramWe) begin
            ram[ramWa] <= ramWd;
        end
    end

    assign bus.devData = s.rdOut;
    assign displayEnable = s.dispEn;
    assign cursorLines = {1'b0, s.curCode} + 4'h1;
    assign autoActive = (s.st == DEV_AWR) || (s.st == DEV_ARD);
endmodule : lcd_cmd_device
`default_nettype wire

// [lcd_cmd_host.sv]
`timescale 1ns/1ps
`default_nettype none
module lcd_cmd_host (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic [3:0]  regAddr,
    input  wire logic [15:0] regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic [15:0]      regRdData,
    output logic             irq,
    lcd_cmd_if.host          bus
);
    import lcd_cmd_pkg::*;

    typedef struct packed {
        host_state_t st;
        logic [9:0]  tx;        // Read flag, command flag, byte
        logic [7:0]  rx;        // Last byte read
        logic [1:0]  cfg;       // Attribute and dual-screen setup
        logic [3:0]  irqStat;   // Sticky events
        logic [3:0]  irqMask;
        logic        ptrLoaded; // Pointer set since reset
        logic        dataReady; // Parameter byte sent, not yet used
        logic [1:0]  autoMode;
        logic        cmdSel;
        logic [7:0]  outByte;
        logic [15:0] rdData;
    } host_regs_t;

    host_regs_t s;      // Current state
    host_regs_t next_s; // Next state
    logic [3:0] ev;     // Events raised this cycle
    logic       refuse; // New order cannot be taken
    logic       ok;     // Polled status allows the transfer
    logic [7:0] b;      // Byte of the new order

    // Strobes follow the state directly
    assign bus.rdEn = (s.st == H_POLL) || (s.st == H_ERRPOLL)
                   || (s.st == H_XFER && s.tx[TX_READ_BIT]);
    assign bus.wrEn = (s.st == H_XFER) && !s.tx[TX_READ_BIT];
    assign bus.cmdSel = s.cmdSel;
    assign bus.hostData = s.outByte;
    assign regRdData = s.rdData;
    assign irq = |(s.irqStat & s.irqMask);
    assign b = regWrData[7:0];

    // Orders that would break the protocol are refused outright
    always_comb begin
        refuse = (s.st != H_IDLE);
        if (regWrData[TX_CMD_BIT] && !regWrData[TX_READ_BIT]) begin
            if (isOp(b, OP_COPY, MSK_EXACT) && (s.cfg != 2'b00)) begin
                refuse = 1'b1;
            end
            if (isOp(b, OP_XFER, MSK_XFER) && !s.ptrLoaded) begin
                refuse = 1'b1;
            end
            if (isOp(b, OP_XFER, MSK_XFER) && !b[0] && !s.dataReady) begin
                refuse = 1'b1;
            end
        end
    end

    // Which status bits must be high before the next byte
    always_comb begin
        case (s.autoMode)
            AUTO_WR: ok = bus.devData[ST_AUTO_WR];
            AUTO_RD: ok = bus.devData[ST_AUTO_RD];
            default: ok = bus.devData[ST_CMD_RDY] && bus.devData[ST_DATA_RDY];
        endcase
    end

    // Register port and sequencer
    always_comb begin
        next_s = s;
        ev = 4'h0;
        next_s.rdData = 16'h0000;
        if (regRd) begin
            case (regAddr)
                REG_RX:    next_s.rdData = {8'h00, s.rx};
                REG_CFG:   next_s.rdData = {14'h0000, s.cfg};
                REG_IRQ:   next_s.rdData = {12'h000, s.irqStat};
                REG_MASK:  next_s.rdData = {12'h000, s.irqMask};
                REG_STATE: next_s.rdData = {12'h000, s.autoMode, s.ptrLoaded,
                                            s.st != H_IDLE};
                default:   next_s.rdData = 16'h0000;
            endcase
        end
        case (s.st)
            H_IDLE: begin
                if (regWr && regAddr == REG_TX) begin
                    if (refuse) begin
                        ev[IRQ_REFUSED] = 1'b1;
                    end else begin
                        next_s.tx = regWrData[9:0];
                        next_s.st = H_POLL;
                    end
                end
            end
            H_POLL: begin
                // Status read strobe is out this cycle
                next_s.st = H_POLLCHK;
            end
            H_POLLCHK: begin
                if (ok) begin
                    next_s.st = H_XFER;
                    next_s.cmdSel = s.tx[TX_CMD_BIT];
                    next_s.outByte = s.tx[7:0];
                end else begin
                    next_s.st = H_POLL;
                    next_s.cmdSel = 1'b1;
                end
            end
            H_XFER: begin
                next_s.cmdSel = 1'b1;
                if (s.tx[TX_READ_BIT]) begin
                    next_s.st = H_RXWAIT;
                end else if (!s.tx[TX_CMD_BIT]) begin
                    next_s.dataReady = (s.autoMode == AUTO_OFF);
                    next_s.st = H_IDLE;
                    ev[IRQ_DONE] = 1'b1;
                end else begin
                    next_s.st = H_IDLE;
                    ev[IRQ_DONE] = 1'b1;
                    if (isOp(s.tx[7:0], OP_PTR_SET, MSK_PTR_SET)) begin
                        next_s.ptrLoaded = 1'b1;
                        next_s.dataReady = 1'b0;
                    end
                    if (isOp(s.tx[7:0], OP_XFER, MSK_XFER) && !s.tx[0]) begin
                        next_s.dataReady = 1'b0;
                    end
                    if (isOp(s.tx[7:0], OP_AUTO, MSK_AUTO)) begin
                        next_s.autoMode = s.tx[1] ? AUTO_OFF
                                        : (s.tx[0] ? AUTO_RD : AUTO_WR);
                    end
                    if (isOp(s.tx[7:0], OP_PEEK, MSK_EXACT)
                        || isOp(s.tx[7:0], OP_COPY, MSK_EXACT)) begin
                        next_s.st = H_ERRPOLL;
                        ev[IRQ_DONE] = 1'b0;
                    end
                end
            end
            H_RXWAIT: begin
                next_s.rx = bus.devData;
                next_s.st = H_IDLE;
                ev[IRQ_RX] = 1'b1;
            end
            H_ERRPOLL: begin
                next_s.st = H_ERRCHK;
            end
            H_ERRCHK: begin
                // Copy may still be busy; wait for ready before judging
                if (bus.devData[ST_CMD_RDY]) begin
                    ev[IRQ_ERR] = bus.devData[ST_PEEK_ERR];
                    ev[IRQ_DONE] = 1'b1;
                    next_s.st = H_IDLE;
                end else begin
                    next_s.st = H_ERRPOLL;
                end
            end
            default: next_s.st = H_IDLE;
        endcase
        if (regWr && regAddr == REG_CFG) begin
            next_s.cfg = regWrData[1:0];
        end
        if (regWr && regAddr == REG_MASK) begin
            next_s.irqMask = regWrData[3:0];
        end
        // Write one clears; an event in the same cycle wins
        if (regWr && regAddr == REG_IRQ) begin
            next_s.irqStat = (s.irqStat & ~regWrData[3:0]) | ev;
        end else begin
            next_s.irqStat = s.irqStat | ev;
        end
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            s <= '0;
            s.st <= H_IDLE;
            s.cmdSel <= 1'b1;
        end else begin
            s <= next_s;
        end
    end
endmodule : lcd_cmd_host
`default_nettype wire

// [lcd_cmd_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface lcd_cmd_if;
    logic       cmdSel;  // High: command or status, low: data
    logic       wrEn;    // One-cycle write strobe from the host
    logic       rdEn;    // One-cycle read strobe from the host
    logic [7:0] hostData; // Byte from the host
    logic [7:0] devData;  // Byte from the device, valid the cycle after rdEn

    modport device (input cmdSel, input wrEn, input rdEn, input hostData, output devData);
    modport host (output cmdSel, output wrEn, output rdEn, output hostData, input devData);
endinterface : lcd_cmd_if
`default_nettype wire

// [lcd_cmd_pkg.sv]
`default_nettype none
package lcd_cmd_pkg;
    // Command opcodes and the masks that pick their fixed bits
    localparam logic [7:0] OP_PTR_SET  = 8'h24; // Address pointer set, two data bytes first
    localparam logic [7:0] MSK_PTR_SET = 8'hFF;
    localparam logic [7:0] OP_DISPLAY  = 8'h90; // Display mode, four enables
    localparam logic [7:0] MSK_DISPLAY = 8'hF0;
    localparam logic [7:0] OP_CURSOR   = 8'hA0; // Cursor pattern, three-bit height
    localparam logic [7:0] MSK_CURSOR  = 8'hF8;
    localparam logic [7:0] OP_AUTO     = 8'hB0; // Auto mode set and reset
    localparam logic [7:0] MSK_AUTO    = 8'hFC;
    localparam logic [7:0] OP_XFER     = 8'hC0; // Single-byte transfer
    localparam logic [7:0] MSK_XFER    = 8'hF8;
    localparam logic [7:0] OP_PEEK     = 8'hE0; // Screen peek
    localparam logic [7:0] OP_COPY     = 8'hE8; // Screen copy
    localparam logic [7:0] MSK_EXACT   = 8'hFF;
    localparam logic [7:0] OP_BITMOD   = 8'hF0; // Bit set or reset
    localparam logic [7:0] MSK_BITMOD  = 8'hF0;
    // Status byte bit positions
    localparam int ST_CMD_RDY  = 0;
    localparam int ST_DATA_RDY = 1;
    localparam int ST_AUTO_RD  = 2;
    localparam int ST_AUTO_WR  = 3;
    localparam int ST_PEEK_ERR = 6;
    // Text and graphic mix codes
    localparam logic [2:0] MIX_OR   = 3'h0;
    localparam logic [2:0] MIX_EXOR = 3'h1;
    localparam logic [2:0] MIX_AND  = 3'h3;
    // Host register offsets and fields
    localparam logic [3:0] REG_TX    = 4'h0;
    localparam logic [3:0] REG_RX    = 4'h1;
    localparam logic [3:0] REG_CFG   = 4'h2;
    localparam logic [3:0] REG_IRQ   = 4'h3;
    localparam logic [3:0] REG_MASK  = 4'h4;
    localparam logic [3:0] REG_STATE = 4'h5;
    localparam int TX_CMD_BIT  = 8;
    localparam int TX_READ_BIT = 9;
    localparam int CFG_ATTR    = 0;
    localparam int CFG_DUAL    = 1;
    localparam int IRQ_DONE    = 0;
    localparam int IRQ_RX      = 1;
    localparam int IRQ_ERR     = 2;
    localparam int IRQ_REFUSED = 3;
    // Auto mode tracking codes
    localparam logic [1:0] AUTO_OFF = 2'h0;
    localparam logic [1:0] AUTO_WR  = 2'h1;
    localparam logic [1:0] AUTO_RD  = 2'h2;

    typedef enum logic [3:0] {
        DEV_IDLE = 4'b0001,
        DEV_AWR  = 4'b0010,
        DEV_ARD  = 4'b0100,
        DEV_COPY = 4'b1000
    } dev_state_t;

    typedef enum logic [6:0] {
        H_IDLE    = 7'b0000001,
        H_POLL    = 7'b0000010,
        H_POLLCHK = 7'b0000100,
        H_XFER    = 7'b0001000,
        H_RXWAIT  = 7'b0010000,
        H_ERRPOLL = 7'b0100000,
        H_ERRCHK  = 7'b1000000
    } host_state_t;

    // Opcode match against a fixed-bit mask
    function automatic logic isOp(input logic [7:0] b, input logic [7:0] op,
                                  input logic [7:0] msk);
        isOp = ((b & msk) == op);
    endfunction : isOp
endpackage : lcd_cmd_pkg
`default_nettype wire

// [lcd_ctrl_display_ram_commands_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("BAD %0t mismatch %h vs %h", $time, (a), (e)); end end
module lcd_ctrl_display_ram_commands_tb;
    import lcd_cmd_pkg::*;
    logic        clk_sys = 1'b0; // System clock
    logic        reset_n = 1'b0; // Sync reset, low active
    logic [3:0]  regAddr = 4'h0; // Register port
    logic [15:0] regWrData = 16'h0000;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic [15:0] regRdData;
    logic        irq;
    logic [3:0]  displayEnable;
    logic [3:0]  cursorLines;
    logic        autoActive;
    int          error_cnt = 0;    // Mismatches
    int          total_checks = 0; // Comparisons
    int          cyc = 0;          // Cycles for the hang guard
    lcd_cmd_if lcd_cmd_if_inst ();
    lcd_cmd_device #(.RAM_AW(10)) lcd_cmd_device_inst (.clk_sys, .reset_n, .bus(lcd_cmd_if_inst),
        .textBase(16'h0100), .gfxBase(16'h0010), .gfxLimit(16'h00FF), .rowBytes(8'h02),
        .mixMode(MIX_OR), .displayEnable, .cursorLines, .autoActive);
    lcd_cmd_host lcd_cmd_host_inst (.clk_sys, .reset_n, .regAddr, .regWrData, .regWr, .regRd,
        .regRdData, .irq, .bus(lcd_cmd_if_inst));
    lcd_cmd_assertions lcd_cmd_assertions_inst (.clk_sys, .reset_n,
        .cmdSel(lcd_cmd_if_inst.cmdSel), .wrEn(lcd_cmd_if_inst.wrEn), .rdEn(lcd_cmd_if_inst.rdEn),
        .hostData(lcd_cmd_if_inst.hostData), .devData(lcd_cmd_if_inst.devData),
        .displayEnable, .cursorLines, .autoActive);
    // Clock generator
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic regW(input logic [3:0] a, input logic [15:0] d);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
        @(posedge clk_sys);
    endtask : regW
    // Data stands only in the cycle after the strobe
    task automatic regR(input logic [3:0] a, output logic [15:0] d);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 d = regRdData;
        @(posedge clk_sys);
    endtask : regR
    // One link byte, then wait until the host is idle
    task automatic send(input logic [7:0] b, input logic c, input logic r);
        logic [15:0] s;
        regW(REG_TX, {6'h00, r, c, b});
        s = 16'h0001;
        for (int i = 0; i < 40 && s[0]; i++) regR(REG_STATE, s);
        `CHK(s[0], 1'b0)
    endtask : send
    task automatic ptr(input logic [15:0] a);
        send(a[7:0], 1'b0, 1'b0);
        send(a[15:8], 1'b0, 1'b0);
        send(8'h24, 1'b1, 1'b0);
    endtask : ptr
    task automatic wrb(input logic [7:0] d, input logic [7:0] c);
        send(d, 1'b0, 1'b0);
        send(c, 1'b1, 1'b0);
    endtask : wrb
    // Data read of the byte the device holds
    task automatic rdd(input logic [7:0] e);
        logic [15:0] v;
        send(8'h00, 1'b0, 1'b1);
        regR(REG_RX, v);
        `CHK(v[7:0], e)
    endtask : rdd
    task automatic rdb(input logic [7:0] c, input logic [7:0] e);
        send(c, 1'b1, 1'b0);
        rdd(e);
    endtask : rdb
    task automatic irqBit(input int b, input logic e);
        logic [15:0] v;
        regR(REG_IRQ, v);
        `CHK(v[b], e)
        regW(REG_IRQ, 16'h000F);
    endtask : irqBit
    task automatic t_single;
        logic [7:0] cmdT[5] = '{8'hC3, 8'hC5, 8'hC5, 8'hC1, 8'hC1};
        logic [7:0] expT[5] = '{8'hA5, 8'h5A, 8'h5A, 8'h5A, 8'hA5};
        logic [15:0] v;
        ptr(16'h0010);
        wrb(8'h5A, 8'hC0);
        wrb(8'hA5, 8'hC0);
        ptr(16'h0011);
        for (int i = 0; i < 5; i++) rdb(cmdT[i], expT[i]);
        send(8'hC0, 1'b1, 1'b0);
        regR(REG_IRQ, v);
        `CHK(v[IRQ_REFUSED], 1'b1)
        `CHK(irq, 1'b0)
        regW(REG_MASK, 16'h0008);
        regR(4'hF, v);
        `CHK(v, 16'h0000)
        `CHK(irq, 1'b1)
        regW(REG_IRQ, 16'h000F);
        regR(REG_MASK, v);
        `CHK(v, 16'h0008)
        `CHK(irq, 1'b0)
        regW(REG_MASK, 16'h0000);
    endtask : t_single
    // Bits, peek and copy on a byte of known contents
    task automatic t_ram;
        ptr(16'h0010);
        send(8'hF8, 1'b1, 1'b0);
        send(8'hF1, 1'b1, 1'b0);
        send(8'hFF, 1'b1, 1'b0);
        rdb(8'hC5, 8'hD9);
        ptr(16'h0100);
        wrb(8'h0F, 8'hC0);
        wrb(8'h30, 8'hC0);
        ptr(16'h0010);
        regW(REG_IRQ, 16'h000F);
        send(8'hE0, 1'b1, 1'b0);
        rdb(8'hC5, 8'hDF);
        irqBit(IRQ_ERR, 1'b0);
        send(8'hE8, 1'b1, 1'b0);
        rdb(8'hC1, 8'hDF);
        rdb(8'hC1, 8'hB5);
        ptr(16'h0005);
        send(8'hE0, 1'b1, 1'b0);
        irqBit(IRQ_ERR, 1'b1);
        send(8'hE8, 1'b1, 1'b0);
        irqBit(IRQ_ERR, 1'b1);
        for (int k = 1; k < 3; k++) begin
            regW(REG_CFG, 16'(k));
            send(8'hE8, 1'b1, 1'b0);
            irqBit(IRQ_REFUSED, 1'b1);
        end
        regW(REG_CFG, 16'h0000);
    endtask : t_ram
    task automatic t_auto;
        ptr(16'h0020);
        send(8'hB0, 1'b1, 1'b0);
        `CHK(autoActive, 1'b1)
        send(8'h90, 1'b1, 1'b0);
        `CHK(displayEnable, 4'hF)
        send(8'h11, 1'b0, 1'b0);
        send(8'h22, 1'b0, 1'b0);
        send(8'hB2, 1'b1, 1'b0);
        `CHK(autoActive, 1'b0)
        ptr(16'h0020);
        send(8'hB1, 1'b1, 1'b0);
        rdd(8'h11);
        rdd(8'h22);
        send(8'hB3, 1'b1, 1'b0);
        `CHK(autoActive, 1'b0)
    endtask : t_auto
    task automatic conclude;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude
    // Hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            conclude();
        end
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        `CHK(displayEnable, 4'h0)
        `CHK(cursorLines, 4'h1)
        for (int i = 0; i < 16; i++) begin
            send({4'h9, 4'(i)}, 1'b1, 1'b0);
            `CHK(displayEnable, 4'(i))
        end
        for (int c = 0; c < 8; c++) begin
            send({5'h14, 3'(c)}, 1'b1, 1'b0);
            `CHK(cursorLines, 4'(c + 1))
        end
        t_single();
        t_ram();
        t_auto();
        conclude();
    end
endmodule : lcd_ctrl_display_ram_commands_tb
`default_nettype wire
